// ===== rtl/csp_sideband.sv
// Processor-side sideband and power-management signal block
// Behaviour
// - The processor floating-point error goes out active low as numeric error.
// - While the address-bit-20 mask is asserted, addresses wrap at one megabyte.
// - Sampling the stop-clock request asserted enters the quick-start state.
// - Quick-start is left only after the stop-clock request is released.
// - Power good goes high once the regulator is stable and control bit CTRL_VR_STBL is set, else released low.
// - Thermal alerts appear on an active-low open-drain output.
// - The two-wire bus lines are open drain and reach only the thermal sensor.
`timescale 1ns/1ns
module csp_sideband (
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_n,
    // AHB-Lite slave
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic      [31:0] o_hrdata,
    output logic             o_hreadyout,
    output logic             o_hresp,
    // Sideband pins from the bridge
    input  wire logic        i_ignore_numeric_error_n,
    input  wire logic        i_init_n,
    input  wire logic        i_maskable_irq_request,
    input  wire logic        i_nmi,
    input  wire logic        i_addr_bit20_mask_n,
    input  wire logic        i_sysmgmt_irq_n,
    input  wire logic        i_stop_clock_request_n,
    input  wire logic        i_suspend_status_n,
    input  wire logic        i_regulator_on,
    // Core address to be wrapped
    input  wire logic [31:0] i_core_addr,
    output logic      [31:0] o_core_addr,
    // Outputs toward the bridge and system
    output logic             o_numeric_error_out_n,
    output logic             o_regulator_power_good,
    output logic             o_regulator_power_good_oe,
    output logic             o_thermal_alert_n_out,
    output logic             o_thermal_alert_n_oe,
    input  wire logic        i_smbus_clock_line,
    output logic             o_smbus_clock_line,
    output logic             o_smbus_clock_line_oe,
    input  wire logic        i_smbus_data_line,
    output logic             o_smbus_data_line,
    output logic             o_smbus_data_line_oe,
    output logic             o_quick_start,
    output logic             o_irq
);

    csp_pkg::csp_side_s side;
    csp_pkg::csp_side_s side_raw;
    csp_pkg::csp_side_s side_q;
    csp_pkg::csp_pstate_e pstate;
    csp_pkg::csp_pstate_e next_pstate;

    logic [31:0] ctrl;
    logic [csp_pkg::EV_NUM-1:0] int_status;
    logic [csp_pkg::EV_NUM-1:0] int_mask;
    logic [csp_pkg::EV_NUM-1:0] ev;
    logic [15:0] vr_cnt;
    logic        vr_stable;
    logic        dp_wr;
    logic        dp_rd;
    logic [7:0]  dp_addr;
    logic        ap_ok;
    logic [31:0] rd_mux;

    assign side_raw = '{
        ignore_numeric_error_n: i_ignore_numeric_error_n,
        init_n:                 i_init_n,
        maskable_irq_request:   i_maskable_irq_request,
        nmi:                    i_nmi,
        addr_bit20_mask_n:      i_addr_bit20_mask_n,
        sysmgmt_irq_n:          i_sysmgmt_irq_n,
        stop_clock_request_n:   i_stop_clock_request_n,
        suspend_status_n:       i_suspend_status_n,
        regulator_on:           i_regulator_on,
        smbus_clock_line:       i_smbus_clock_line,
        smbus_data_line:        i_smbus_data_line
    };

    // Pin inputs through three flops
    csp_sync #(
        .W       (csp_pkg::SYNC_W),
        .RST_VAL (csp_pkg::SIDE_IDLE)
    ) u_sync (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_async    (side_raw),
        .o_sync     (side)
    );

    // Previous sample for edge events
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            side_q <= csp_pkg::csp_side_s'(csp_pkg::SIDE_IDLE);
        end else begin
            side_q <= side;
        end
    end

    // Quick-start state machine
    always_comb begin
        next_pstate = pstate;
        case (pstate)
            csp_pkg::CSP_RUN: begin
                if (!side.stop_clock_request_n) begin
                    next_pstate = csp_pkg::CSP_QSTRT;
                end
            end
            csp_pkg::CSP_QSTRT: begin
                if (side.stop_clock_request_n) begin
                    next_pstate = csp_pkg::CSP_EXIT;
                end
            end
            csp_pkg::CSP_EXIT: begin
                next_pstate = csp_pkg::CSP_RUN;
            end
            default: begin
                next_pstate = csp_pkg::CSP_RUN;
            end
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pstate <= csp_pkg::CSP_RUN;
            o_quick_start <= 1'b0;
        end else begin
            pstate <= next_pstate;
            o_quick_start <= (next_pstate == csp_pkg::CSP_QSTRT);
        end
    end

    // Address wrap at one megabyte
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_core_addr <= 32'h0000_0000;
        end else begin
            o_core_addr <= i_core_addr;
            if (!side.addr_bit20_mask_n) begin
                o_core_addr[20] <= 1'b0;
            end
        end
    end

    // Regulator settle counter and power good
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            vr_cnt <= 16'h0000;
            vr_stable <= 1'b0;
        end else if (!side.regulator_on) begin
            vr_cnt <= 16'h0000;
            vr_stable <= 1'b0;
        end else if (vr_cnt == 16'(csp_pkg::VR_SETTLE_CYC - 1)) begin
            vr_stable <= 1'b1;
        end else begin
            vr_cnt <= vr_cnt + 16'h0001;
        end
    end

    // Output pins
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_numeric_error_out_n <= 1'b1;
            o_regulator_power_good <= 1'b0;
            o_regulator_power_good_oe <= 1'b0;
            o_thermal_alert_n_out <= 1'b0;
            o_thermal_alert_n_oe <= 1'b0;
            o_smbus_clock_line <= 1'b0;
            o_smbus_clock_line_oe <= 1'b0;
            o_smbus_data_line <= 1'b0;
            o_smbus_data_line_oe <= 1'b0;
        end else begin
            o_numeric_error_out_n <= !ctrl[csp_pkg::CTRL_FP_ERR];
            o_regulator_power_good <= vr_stable
                && ctrl[csp_pkg::CTRL_VR_STBL];
            o_regulator_power_good_oe <= vr_stable
                && ctrl[csp_pkg::CTRL_VR_STBL];
            o_thermal_alert_n_oe <= ctrl[csp_pkg::CTRL_TH_ALERT];
            o_smbus_clock_line_oe <= ctrl[csp_pkg::CTRL_SMB_CLK];
            o_smbus_data_line_oe <= ctrl[csp_pkg::CTRL_SMB_DAT];
        end
    end

    // Events from the bridge pins, plus the wake event on quick-start exit
    assign ev[csp_pkg::EV_INIT] = !side.init_n && side_q.init_n;
    assign ev[csp_pkg::EV_NMI]  = side.nmi && !side_q.nmi;
    assign ev[csp_pkg::EV_SMI]  = !side.sysmgmt_irq_n
                                  && side_q.sysmgmt_irq_n;
    assign ev[csp_pkg::EV_STOP] = !side.stop_clock_request_n
                                  && side_q.stop_clock_request_n;
    assign ev[csp_pkg::EV_WAKE] = (pstate == csp_pkg::CSP_EXIT);
    assign ev[csp_pkg::EV_SUSP] = !side.suspend_status_n
                                  && side_q.suspend_status_n;

    // AHB-Lite address phase capture
    assign ap_ok = i_hsel && i_hready && i_htrans[1];

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            dp_wr <= 1'b0;
            dp_rd <= 1'b0;
            dp_addr <= 8'h00;
        end else if (i_hready) begin
            dp_wr <= ap_ok && i_hwrite;
            dp_rd <= ap_ok && !i_hwrite;
            dp_addr <= i_haddr[7:0];
        end
    end

    // Control register
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl <= csp_pkg::CTRL_RST;
        end else if (dp_wr && dp_addr == csp_pkg::CTRL_OFF) begin
            ctrl <= i_hwdata & 32'h0000_001F;
        end
    end

    // Mask register
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            int_mask <= csp_pkg::INTMSK_RST[csp_pkg::EV_NUM-1:0];
        end else if (dp_wr && dp_addr == csp_pkg::INTMSK_OFF) begin
            int_mask <= i_hwdata[csp_pkg::EV_NUM-1:0];
        end
    end

    // Sticky status, set wins over write-one clear
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            int_status <= '0;
        end else if (dp_wr && dp_addr == csp_pkg::INTST_OFF) begin
            int_status <= (int_status & ~i_hwdata[csp_pkg::EV_NUM-1:0])
                          | ev;
        end else begin
            int_status <= int_status | ev;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(int_status & int_mask);
        end
    end

    // Read mux
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (i_haddr[7:0])
            csp_pkg::CTRL_OFF:   rd_mux = ctrl;
            csp_pkg::STATUS_OFF: begin
                rd_mux[2:0] = pstate;
                rd_mux[3] = vr_stable;
            end
            csp_pkg::INTST_OFF:  rd_mux[csp_pkg::EV_NUM-1:0] = int_status;
            csp_pkg::INTMSK_OFF: rd_mux[csp_pkg::EV_NUM-1:0] = int_mask;
            csp_pkg::PINS_OFF:   rd_mux[csp_pkg::SYNC_W-1:0] = side;
            default:             rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data registered for next-cycle data phase
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_hrdata <= 32'h0000_0000;
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end else begin
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
            if (ap_ok && !i_hwrite) begin
                o_hrdata <= rd_mux;
            end
        end
    end

    // Assertions
    property p_qs_enter;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (pstate == csp_pkg::CSP_RUN && !side.stop_clock_request_n)
            |=> (pstate == csp_pkg::CSP_QSTRT);
    endproperty
    a_qs_enter: assert property (p_qs_enter)
        else $error("quick start not entered");

    property p_qs_hold;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (pstate == csp_pkg::CSP_QSTRT && !side.stop_clock_request_n)
            |=> (pstate == csp_pkg::CSP_QSTRT);
    endproperty
    a_qs_hold: assert property (p_qs_hold)
        else $error("quick start left early");

    property p_wrap;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        !side.addr_bit20_mask_n |=> !o_core_addr[20];
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("address bit 20 not masked");

    property p_numeric_error_out_n;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        ctrl[csp_pkg::CTRL_FP_ERR] |=> !o_numeric_error_out_n;
    endproperty
    a_numeric_error_out_n: assert property (p_numeric_error_out_n)
        else $error("numeric error not driven");

    property p_pg_off;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        !side.regulator_on |=> ##1 !o_regulator_power_good;
    endproperty
    a_pg_off: assert property (p_pg_off)
        else $error("power good with regulator off");

    property p_od_low;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        !o_thermal_alert_n_out && !o_smbus_clock_line
            && !o_smbus_data_line;
    endproperty
    a_od_low: assert property (p_od_low)
        else $error("open drain driven high");

    property p_th_alert;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        $rose(ctrl[csp_pkg::CTRL_TH_ALERT]) |=> o_thermal_alert_n_oe;
    endproperty
    a_th_alert: assert property (p_th_alert)
        else $error("thermal alert not asserted");

    property p_smi_sticky;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        ev[csp_pkg::EV_SMI] |=> int_status[csp_pkg::EV_SMI];
    endproperty
    a_smi_sticky: assert property (p_smi_sticky)
        else $error("management event lost");

    c_qs: cover property (@(posedge i_core_clk)
        pstate == csp_pkg::CSP_EXIT);
    c_irq: cover property (@(posedge i_core_clk) $rose(o_irq));
    c_pg: cover property (@(posedge i_core_clk)
        $rose(o_regulator_power_good));

endmodule : csp_sideband

// ===== rtl/csp_pkg.sv
// Package: register map, layouts and constants for the sideband block
package csp_pkg;

    localparam logic [7:0] CTRL_OFF   = 8'h00;
    localparam logic [7:0] STATUS_OFF = 8'h04;
    localparam logic [7:0] INTST_OFF  = 8'h08;
    localparam logic [7:0] INTMSK_OFF = 8'h0C;
    localparam logic [7:0] PINS_OFF   = 8'h10;

    localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
    localparam logic [31:0] INTMSK_RST = 32'h0000_0000;

    // Control bits
    localparam int CTRL_FP_ERR   = 0;
    localparam int CTRL_VR_STBL  = 1;
    localparam int CTRL_TH_ALERT = 2;
    localparam int CTRL_SMB_CLK  = 3;
    localparam int CTRL_SMB_DAT  = 4;

    // Event bits in interrupt status and mask
    localparam int EV_INIT  = 0;
    localparam int EV_NMI   = 1;
    localparam int EV_SMI   = 2;
    localparam int EV_STOP  = 3;
    localparam int EV_WAKE  = 4;
    localparam int EV_SUSP  = 5;
    localparam int EV_NUM   = 6;

    // Regulator settle time before power good
    localparam int  VR_SETTLE_NS  = 1000;
    localparam int  CLK_PERIOD_NS = 4;
    localparam int  VR_SETTLE_CYC = (VR_SETTLE_NS + CLK_PERIOD_NS - 1)
                                    / CLK_PERIOD_NS;
    localparam int  SYNC_W        = 11;
    // Idle pin levels in struct order, so reset shows no edges
    localparam logic [SYNC_W-1:0] SIDE_IDLE = 11'h67B;

    typedef enum logic [2:0] {
        CSP_RUN   = 3'b001,
        CSP_QSTRT = 3'b010,
        CSP_EXIT  = 3'b100
    } csp_pstate_e;

    // Synchronised sideband inputs
    typedef struct packed {
        logic ignore_numeric_error_n;
        logic init_n;
        logic maskable_irq_request;
        logic nmi;
        logic addr_bit20_mask_n;
        logic sysmgmt_irq_n;
        logic stop_clock_request_n;
        logic suspend_status_n;
        logic regulator_on;
        logic smbus_clock_line;
        logic smbus_data_line;
    } csp_side_s;

endpackage : csp_pkg

// ===== rtl/csp_sync.sv
// Three-flop synchroniser bank for pin inputs
`timescale 1ns/1ns
module csp_sync #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         i_core_clk,
    input  wire logic         i_rst_n,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta;
    logic [W-1:0] seen;

    // Flops reset to the pins' idle levels
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta <= RST_VAL;
            seen <= RST_VAL;
            o_sync <= RST_VAL;
        end else begin
            meta <= i_async;
            seen <= meta;
            o_sync <= seen;
        end
    end
endmodule : csp_sync

// ===== tb/csp_bridge_model.sv
// Bridge and regulator stand-in for the sideband pins
`timescale 1ns/1ns
module csp_bridge_model (
    input  wire logic         i_core_clk,
    input  wire logic         i_clk_oe,
    input  wire logic         i_dat_oe,
    output csp_pkg::csp_side_s o_side
);
    logic [10:0] pins;
    logic        pull_clk;
    logic        pull_dat;

    initial begin
        pins     = csp_pkg::SIDE_IDLE;
        pull_clk = 1'b0;
        pull_dat = 1'b0;
    end

    // Pull-up wins unless some party pulls low
    always_comb begin
        o_side                  = csp_pkg::csp_side_s'(pins);
        o_side.smbus_clock_line = ~(i_clk_oe | pull_clk);
        o_side.smbus_data_line  = ~(i_dat_oe | pull_dat);
    end

    // Level pins changed right after a clock edge
    task automatic set_pin(input int idx, input logic v);
        @(posedge i_core_clk);
        pins[idx] <= v;
    endtask : set_pin

    task automatic pull(input logic c, input logic d);
        @(posedge i_core_clk);
        pull_clk <= c;
        pull_dat <= d;
    endtask : pull
endmodule : csp_bridge_model

// ===== tb/csp_sideband_bench.sv
// Self-checking bench for the sideband block
`timescale 1ns/1ns
module csp_sideband_bench;
    localparam int LIMIT = 20000;
    logic        i_core_clk;
    logic        i_rst_n;
    logic [31:0] haddr, hwdata, hrdata, cad, cout, rdv;
    logic [1:0]  htrans;
    logic        hwrite, hrdy, hresp;
    logic        nerr, pg, pg_oe, th, th_oe, sc, sc_oe, sd, sd_oe;
    logic        qs, irq;
    csp_pkg::csp_side_s side;
    int          num_errors, checks_done, cycles;

    csp_bridge_model MDL (.i_core_clk(i_core_clk), .i_clk_oe(sc_oe),
        .i_dat_oe(sd_oe), .o_side(side));

    csp_sideband DUT (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
        .i_hsel(1'b1), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
        .i_hready(hrdy), .o_hrdata(hrdata), .o_hreadyout(hrdy),
        .o_hresp(hresp),
        .i_ignore_numeric_error_n(side.ignore_numeric_error_n),
        .i_init_n(side.init_n),
        .i_maskable_irq_request(side.maskable_irq_request),
        .i_nmi(side.nmi), .i_addr_bit20_mask_n(side.addr_bit20_mask_n),
        .i_sysmgmt_irq_n(side.sysmgmt_irq_n),
        .i_stop_clock_request_n(side.stop_clock_request_n),
        .i_suspend_status_n(side.suspend_status_n),
        .i_regulator_on(side.regulator_on),
        .i_core_addr(cad), .o_core_addr(cout),
        .o_numeric_error_out_n(nerr), .o_regulator_power_good(pg),
        .o_regulator_power_good_oe(pg_oe),
        .o_thermal_alert_n_out(th), .o_thermal_alert_n_oe(th_oe),
        .i_smbus_clock_line(side.smbus_clock_line),
        .o_smbus_clock_line(sc), .o_smbus_clock_line_oe(sc_oe),
        .i_smbus_data_line(side.smbus_data_line),
        .o_smbus_data_line(sd), .o_smbus_data_line_oe(sd_oe),
        .o_quick_start(qs), .o_irq(irq));

    always #2 i_core_clk = ~i_core_clk;

    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : summarize

    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            num_errors++;
            summarize();
        end
    end

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask : chk_bit

    task automatic cyc(input int n);
        repeat (n) @(posedge i_core_clk);
    endtask : cyc

    // Single transfer: address phase, then data phase
    task automatic ahb(input logic wr, input logic [7:0] off,
                       input logic [31:0] wd);
        @(posedge i_core_clk);
        haddr  <= {24'h00_0000, off};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge i_core_clk); while (hrdy !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge i_core_clk); while (hrdy !== 1'b1);
        rdv = hrdata;
    endtask : ahb

    task automatic wr(input logic [7:0] off, input logic [31:0] d);
        ahb(1'b1, off, d);
    endtask : wr

    task automatic rd(input logic [7:0] off);
        ahb(1'b0, off, 32'h0000_0000);
    endtask : rd

    task automatic t_regs;
        rd(csp_pkg::CTRL_OFF);
        chk_word(rdv, csp_pkg::CTRL_RST);
        rd(csp_pkg::INTMSK_OFF);
        chk_word(rdv, csp_pkg::INTMSK_RST);
        rd(csp_pkg::INTST_OFF);
        chk_word(rdv, 32'h0000_0000);
        chk_bit(qs, 1'b0);
        wr(8'h40, 32'hFFFF_FFFF);
        rd(8'h40);
        chk_word(rdv, 32'h0000_0000);
        chk_bit(hresp, 1'b0);
        $display("register test done");
    endtask : t_regs

    task automatic t_numerr;
        wr(csp_pkg::CTRL_OFF, 32'h0000_0001);
        cyc(2);
        chk_bit(nerr, 1'b0);
        wr(csp_pkg::CTRL_OFF, 32'h0000_0000);
        cyc(2);
        chk_bit(nerr, 1'b1);
        $display("numeric error test done");
    endtask : t_numerr

    task automatic t_wrap;
        cad <= 32'h0013_5678;
        MDL.set_pin(6, 1'b0);
        cyc(8);
        chk_word(cout, 32'h0003_5678);
        MDL.set_pin(6, 1'b1);
        cyc(8);
        chk_word(cout, 32'h0013_5678);
        $display("wrap test done");
    endtask : t_wrap

    task automatic t_stop;
        MDL.set_pin(4, 1'b0);
        cyc(8);
        chk_bit(qs, 1'b1);
        cyc(30);
        rd(csp_pkg::STATUS_OFF);
        chk_word({29'h0, rdv[2:0]}, {29'h0, csp_pkg::CSP_QSTRT});
        MDL.set_pin(4, 1'b1);
        cyc(8);
        chk_bit(qs, 1'b0);
        rd(csp_pkg::INTST_OFF);
        chk_word(rdv, 32'h0000_0018);
        chk_bit(irq, 1'b0);
        wr(csp_pkg::INTMSK_OFF, 32'h0000_0010);
        cyc(2);
        chk_bit(irq, 1'b1);
        wr(csp_pkg::INTST_OFF, 32'h0000_0010);
        cyc(2);
        chk_bit(irq, 1'b0);
        rd(csp_pkg::INTST_OFF);
        chk_word(rdv, 32'h0000_0008);
        wr(csp_pkg::INTST_OFF, 32'hFFFF_FFFF);
        wr(csp_pkg::INTMSK_OFF, 32'h0000_0000);
        $display("stop clock test done");
    endtask : t_stop

    task automatic t_events;
        int pin[4] = '{9, 7, 5, 3};
        logic act[4] = '{1'b0, 1'b1, 1'b0, 1'b0};
        int ev[4] = '{0, 1, 2, 5};
        for (int i = 0; i < 4; i++) begin
            MDL.set_pin(pin[i], act[i]);
            cyc(8);
            rd(csp_pkg::INTST_OFF);
            chk_word(rdv, 32'h0000_0001 << ev[i]);
            MDL.set_pin(pin[i], ~act[i]);
            cyc(8);
            wr(csp_pkg::INTST_OFF, 32'hFFFF_FFFF);
        end
        MDL.set_pin(8, 1'b1);
        MDL.set_pin(10, 1'b0);
        cyc(8);
        rd(csp_pkg::PINS_OFF);
        chk_word({30'h0, rdv[10], rdv[8]}, 32'h0000_0001);
        $display("event test done");
    endtask : t_events

    task automatic t_power;
        wr(csp_pkg::CTRL_OFF, 32'h0000_0002);
        MDL.set_pin(2, 1'b1);
        cyc(200);
        chk_bit(pg_oe, 1'b0);
        cyc(70);
        chk_bit(pg & pg_oe, 1'b1);
        rd(csp_pkg::STATUS_OFF);
        chk_bit(rdv[3], 1'b1);
        MDL.set_pin(2, 1'b0);
        cyc(8);
        chk_bit(pg_oe, 1'b0);
        wr(csp_pkg::CTRL_OFF, 32'h0000_0000);
        $display("power good test done");
    endtask : t_power

    task automatic t_od;
        wr(csp_pkg::CTRL_OFF, 32'h0000_001C);
        cyc(2);
        chk_word({29'h0, th_oe, sc_oe, sd_oe}, 32'h0000_0007);
        chk_word({29'h0, th, sc, sd}, 32'h0000_0000);
        cyc(8);
        rd(csp_pkg::PINS_OFF);
        chk_word({30'h0, rdv[1:0]}, 32'h0000_0000);
        wr(csp_pkg::CTRL_OFF, 32'h0000_0000);
        cyc(2);
        chk_word({29'h0, th_oe, sc_oe, sd_oe}, 32'h0000_0000);
        MDL.pull(1'b0, 1'b1);
        cyc(8);
        rd(csp_pkg::PINS_OFF);
        chk_word({30'h0, rdv[1:0]}, 32'h0000_0002);
        MDL.pull(1'b0, 1'b0);
        $display("open drain test done");
    endtask : t_od

    initial begin
        i_core_clk = 1'b0;
        i_rst_n    = 1'b0;
        haddr      = 32'h0000_0000;
        hwdata     = 32'h0000_0000;
        htrans     = 2'h0;
        hwrite     = 1'b0;
        cad        = 32'h0000_0000;
        repeat (6) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        t_regs();
        t_numerr();
        t_wrap();
        t_stop();
        t_events();
        t_power();
        t_od();
        summarize();
    end
endmodule : csp_sideband_bench
